// ### rtl/sdcr_pkg.sv
`default_nettype none
package sdcr_pkg;
  localparam int WORD_W = 24;
  localparam int SEL_W = 3;
  localparam logic [SEL_W-1:0] SEL_CHANNEL = 3'h0;
  localparam logic [SEL_W-1:0] SEL_DENREF = 3'h1;
  localparam logic [SEL_W-1:0] SEL_PHASE = 3'h2;
  localparam logic [SEL_W-1:0] SEL_FUNCTION = 3'h3;
  localparam logic [SEL_W-1:0] SEL_PUMP = 3'h4;
  localparam int SEL_LSB = 0;
  localparam int INT_MSB = 23;
  localparam int INT_LSB = 15;
  localparam int NUM_MSB = 14;
  localparam int NUM_LSB = 3;
  localparam int BOOST_BIT = 23;
  localparam int HALVE_BIT = 22;
  localparam int PRESCALE_BIT = 20;
  localparam int DOUBLE_BIT = 19;
  localparam int RDIV_MSB = 18;
  localparam int RDIV_LSB = 15;
  localparam int DEN_MSB = 14;
  localparam int DEN_LSB = 3;
  localparam int PHASE_MSB = 14;
  localparam int PHASE_LSB = 3;
  localparam int GROUND_BIT = 5;
  localparam int POLARITY_BIT = 3;
  localparam int COUNT_MSB = 13;
  localparam int COUNT_LSB = 5;
  localparam int TSEL_MSB = 4;
  localparam int TSEL_LSB = 3;
  localparam logic [1:0] TSEL_PAIR = 2'h0;
  localparam logic [1:0] TSEL_THIRD = 2'h1;
  localparam logic [1:0] TSEL_CURRENT = 2'h2;
  localparam int COUNT_W = 9;
  localparam int TICKS_PER_UNIT = 4;
  localparam int TICK_W = 2;
  localparam logic [TICK_W-1:0] TICK_LAST = 2'h3;
  localparam logic [3:0] RDIV_RESET = 4'h1;
  localparam logic [11:0] DEN_RESET = 12'h00d;
  localparam logic [8:0] INT_RESET = 9'h01a;

  typedef struct packed {
    logic        pump_boost;
    logic        ref_halve;
    logic        prescale_89;
    logic        doubler_en;
    logic [3:0]  ref_div;
    logic [11:0] fraction_denominator;
    logic [11:0] phase_seed;
  } sdcr_shadow_t;

  typedef struct packed {
    logic [8:0]  int_value;
    logic [11:0] fraction_numerator;
  } sdcr_channel_t;
endpackage
`default_nettype wire

// ### rtl/sdcr_timeout.sv
`default_nettype none
module sdcr_timeout
  import sdcr_pkg::*;
#(
  parameter int W = 9
) (
  input  wire logic         clk_sys_i,
  input  wire logic         reset_i,
  input  wire logic         detector_tick_i,
  input  wire logic         start_i,
  input  wire logic [W-1:0] limit_i,
  output logic              active_o
);
  logic [W-1:0]      units_reg;
  logic [TICK_W-1:0] sub_reg;
  logic              active_reg;
  wire               unit_done = detector_tick_i && (sub_reg == TICK_LAST);
  wire               last_unit = unit_done && (units_reg == W'(1));

  // Each count unit is four detector cycles; a zero count never opens the window.
  always_ff @(posedge clk_sys_i) begin // see (RULE22)
    if (reset_i) begin
      units_reg <= '0;
      sub_reg <= '0;
      active_reg <= 1'b0;
    end else if (start_i) begin
      units_reg <= limit_i;
      sub_reg <= '0;
      active_reg <= (limit_i != '0);
    end else if (active_reg && detector_tick_i) begin
      sub_reg <= sub_reg + TICK_W'(1);
      if (unit_done) begin
        units_reg <= units_reg - W'(1);
      end
      if (last_unit) begin
        active_reg <= 1'b0;
      end
    end
  end

  assign active_o = active_reg;

  chk_zero_count_idle: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (RULE22)
    start_i && limit_i == '0 |=> !active_o)
    else $error("Zero timeout count opened the window.");
endmodule
`default_nettype wire

// ### rtl/sdcr_ref_path.sv
`default_nettype none
module sdcr_ref_path
  import sdcr_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic       reset_i,
  input  wire logic       ref_edge_i,
  input  wire logic       doubler_en_i,
  input  wire logic       ref_halve_i,
  input  wire logic [3:0] ref_div_i,
  output logic            detector_tick_o
);
  logic [4:0] cnt_reg;
  logic       half_reg;
  logic       tick_reg;
  wire [4:0]  span = doubler_en_i ? {1'b0, ref_div_i} : {ref_div_i, 1'b0};
  wire        div_out = ref_edge_i && (cnt_reg + 5'h1 >= span);

  // Reference edges here are half-cycles, so the doubler halves the divide span.
  always_ff @(posedge clk_sys_i) begin // see (RULE10) see (RULE11)
    if (reset_i) begin
      cnt_reg <= '0;
      half_reg <= 1'b0;
      tick_reg <= 1'b0;
    end else begin
      if (ref_edge_i) begin
        cnt_reg <= div_out ? 5'h0 : cnt_reg + 5'h1;
      end
      if (div_out) begin
        half_reg <= ~half_reg;
      end
      tick_reg <= div_out && (!ref_halve_i || half_reg); // see (RULE7)
    end
  end

  assign detector_tick_o = tick_reg;
endmodule
`default_nettype wire

// ### rtl/sdcr_config_bank.sv
// Overview of operation
// (RULE1) Select code 000 loads the channel divide word.
// (RULE2) Integer divide sits in bits 23..15; host keeps it 26 to 511.
// (RULE3) Fraction numerator sits in bits 14..3; host keeps it below denominator.
// (RULE4) Denominator, divider, doubler, halver and boost wait for the channel write.
// (RULE5) Select code 001 loads the denominator/reference word.
// (RULE6) Boost set raises pump current 25 percent after the channel write.
// (RULE7) Halver set adds a toggle stage before the phase detector.
// (RULE8) Host writes bit 21 of the denominator/reference word as zero.
// (RULE9) Host picks 8/9 prescaler above 3 GHz; minimum integer then 80.
// (RULE10) Doubler enable inserts the doubler ahead of the reference divider.
// (RULE11) Reference divider divides by its value; host uses 1 to 15.
// (RULE12) Host keeps the denominator between 13 and 4095.
// (RULE13) Select code 010 loads the phase word; host writes bit 15 zero.
// (RULE14) Twelve-bit phase word seeds the sigma-delta modulator.
// (RULE15) Phase word waits for the next channel write.
// (RULE16) Host spaces channel writes by denominator multiples of reference cycles.
// (RULE17) Host writes both synthesizers in one reference cycle for coherence.
// (RULE18) Select code 011 loads the function word, normally at start-up.
// (RULE19) Pump ground bit low grounds pump outputs.
// (RULE20) Polarity bit one is positive detector polarity, zero negative.
// (RULE21) Host writes function bits 15..6 as 0x001 and bit 4 one.
// (RULE22) Nine-bit count in bits 13..5, selector bits 4..3; unit is four cycles.
// (RULE23) Selector 10 pump current, 01 third switch, 00 switch pair.
// (RULE24) Detector cycle after channel write loads dividers, starts timers, fast lock.
// (RULE25) Host writes pump timer word bits 23..14 as 0x001.
// (RULE26) All shadowed fields move to active copies together in one cycle.
`default_nettype none
module sdcr_config_bank
  import sdcr_pkg::*;
(
  input  wire logic                  clk_sys_i,
  input  wire logic                  reset_i,
  input  wire logic                  load_i,
  input  wire logic [WORD_W-1:0]     word_i,
  input  wire logic                  ref_edge_i,
  output sdcr_pkg::sdcr_channel_t    channel_o,
  output sdcr_pkg::sdcr_shadow_t     active_o,
  output logic                       detector_tick_o,
  output logic                       modulator_load_o,
  output logic                       fast_lock_o,
  output logic                       pump_boost_o,
  output logic                       pump_ground_o,
  output logic                       detector_positive_o,
  output logic                       pair_switch_closed_o,
  output logic                       third_switch_closed_o
);
  import sdcr_pkg::*;

  sdcr_shadow_t  shadow_reg;
  sdcr_shadow_t  active_reg;
  sdcr_channel_t staged_reg;
  sdcr_channel_t channel_reg;
  logic          pending_reg;
  logic          modload_reg;
  logic          ground_n_reg;
  logic          polarity_reg;
  logic [COUNT_W-1:0] current_lim_reg;
  logic [COUNT_W-1:0] third_lim_reg;
  logic [COUNT_W-1:0] pair_lim_reg;
  logic          current_active;
  logic          third_active;
  logic          pair_active;

  wire [SEL_W-1:0] sel = word_i[SEL_LSB +: SEL_W];
  wire hit_channel  = load_i && (sel == SEL_CHANNEL); // see (RULE1)
  wire hit_denref   = load_i && (sel == SEL_DENREF); // see (RULE5)
  wire hit_phase    = load_i && (sel == SEL_PHASE); // see (RULE13)
  wire hit_function = load_i && (sel == SEL_FUNCTION); // see (RULE18)
  wire hit_pump     = load_i && (sel == SEL_PUMP);
  wire [1:0] tsel   = word_i[TSEL_MSB:TSEL_LSB];
  wire [COUNT_W-1:0] count_field = word_i[COUNT_MSB:COUNT_LSB];
  wire apply        = pending_reg && detector_tick_o;

  sdcr_shadow_t shadow_next;
  always_comb begin
    shadow_next = shadow_reg;
    if (hit_denref) begin // see (RULE4)
      shadow_next.pump_boost = word_i[BOOST_BIT];
      shadow_next.ref_halve = word_i[HALVE_BIT];
      shadow_next.prescale_89 = word_i[PRESCALE_BIT];
      shadow_next.doubler_en = word_i[DOUBLE_BIT];
      shadow_next.ref_div = word_i[RDIV_MSB:RDIV_LSB];
      shadow_next.fraction_denominator = word_i[DEN_MSB:DEN_LSB];
    end
    if (hit_phase) begin // see (RULE15)
      shadow_next.phase_seed = word_i[PHASE_MSB:PHASE_LSB];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      shadow_reg <= '{ref_div: RDIV_RESET, fraction_denominator: DEN_RESET, default: '0};
    end else begin
      shadow_reg <= shadow_next;
    end
  end

  // The staged channel word waits here until the next detector tick applies it.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      staged_reg <= '{int_value: INT_RESET, fraction_numerator: '0};
      pending_reg <= 1'b0;
    end else if (hit_channel) begin
      staged_reg.int_value <= word_i[INT_MSB:INT_LSB]; // see (RULE2)
      staged_reg.fraction_numerator <= word_i[NUM_MSB:NUM_LSB]; // see (RULE3)
      pending_reg <= 1'b1;
    end else if (apply) begin
      pending_reg <= 1'b0;
    end
  end

  // A channel write marks the shadow as committed: the shadow is copied when the
  // detector tick arrives, so the host must not rewrite shadows in between.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      active_reg <= '{ref_div: RDIV_RESET, fraction_denominator: DEN_RESET, default: '0};
      channel_reg <= '{int_value: INT_RESET, fraction_numerator: '0};
      modload_reg <= 1'b0;
    end else begin
      modload_reg <= apply;
      if (apply) begin
        active_reg <= shadow_reg; // see (RULE26) see (RULE24)
        channel_reg <= staged_reg; // see (RULE24)
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      ground_n_reg <= 1'b0;
      polarity_reg <= 1'b0;
    end else if (hit_function) begin
      ground_n_reg <= word_i[GROUND_BIT]; // see (RULE19)
      polarity_reg <= word_i[POLARITY_BIT]; // see (RULE20)
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      current_lim_reg <= '0;
      third_lim_reg <= '0;
      pair_lim_reg <= '0;
    end else if (hit_pump) begin
      if (tsel == TSEL_CURRENT) begin // see (RULE23)
        current_lim_reg <= count_field; // see (RULE22)
      end
      if (tsel == TSEL_THIRD) begin
        third_lim_reg <= count_field;
      end
      if (tsel == TSEL_PAIR) begin
        pair_lim_reg <= count_field;
      end
    end
  end

  sdcr_ref_path u_ref (
    .clk_sys_i       (clk_sys_i),
    .reset_i         (reset_i),
    .ref_edge_i      (ref_edge_i),
    .doubler_en_i    (active_reg.doubler_en),
    .ref_halve_i     (active_reg.ref_halve),
    .ref_div_i       (active_reg.ref_div),
    .detector_tick_o (detector_tick_o)
  );

  sdcr_timeout #(.W(COUNT_W)) u_current (
    .clk_sys_i       (clk_sys_i),
    .reset_i         (reset_i),
    .detector_tick_i (detector_tick_o),
    .start_i         (apply),
    .limit_i         (current_lim_reg),
    .active_o        (current_active)
  );

  sdcr_timeout #(.W(COUNT_W)) u_third (
    .clk_sys_i       (clk_sys_i),
    .reset_i         (reset_i),
    .detector_tick_i (detector_tick_o),
    .start_i         (apply),
    .limit_i         (third_lim_reg),
    .active_o        (third_active)
  );

  sdcr_timeout #(.W(COUNT_W)) u_pair (
    .clk_sys_i       (clk_sys_i),
    .reset_i         (reset_i),
    .detector_tick_i (detector_tick_o),
    .start_i         (apply),
    .limit_i         (pair_lim_reg),
    .active_o        (pair_active)
  );

  assign channel_o = channel_reg;
  assign active_o = active_reg; // see (RULE14)
  assign modulator_load_o = modload_reg;
  assign fast_lock_o = current_active; // see (RULE24)
  assign pump_boost_o = active_reg.pump_boost; // see (RULE6)
  assign pump_ground_o = !ground_n_reg; // see (RULE19)
  assign detector_positive_o = polarity_reg;
  assign pair_switch_closed_o = pair_active;
  assign third_switch_closed_o = third_active;

  sequence s_channel_write;
    hit_channel && !pending_reg;
  endsequence

  chk_channel_arms: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (RULE1)
    s_channel_write |=> pending_reg && staged_reg.int_value == $past(word_i[INT_MSB:INT_LSB]))
    else $error("Channel write did not arm the staged word.");
  chk_shadow_holds: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (RULE4)
    !apply |=> active_reg == $past(active_reg))
    else $error("Active configuration changed without a channel apply.");
  chk_apply_atomic: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (RULE26)
    apply |=> active_reg == $past(shadow_reg) && modload_reg)
    else $error("Shadow did not move to active as one unit.");
  chk_denref_shadow: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (RULE5)
    hit_denref |=> shadow_reg.fraction_denominator == $past(word_i[DEN_MSB:DEN_LSB]))
    else $error("Denominator word not captured in shadow.");
  chk_phase_shadow: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (RULE13)
    hit_phase |=> shadow_reg.phase_seed == $past(word_i[PHASE_MSB:PHASE_LSB]))
    else $error("Phase word not captured in shadow.");
  chk_ground_map: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (RULE19)
    hit_function |=> pump_ground_o == !$past(word_i[GROUND_BIT]))
    else $error("Pump ground did not follow the function word.");
  chk_polarity_map: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (RULE20)
    hit_function |=> detector_positive_o == $past(word_i[POLARITY_BIT]))
    else $error("Detector polarity did not follow the function word.");
  chk_timer_select: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (RULE23)
    hit_pump && tsel == TSEL_CURRENT |=> current_lim_reg == $past(count_field))
    else $error("Pump current timeout not programmed by selector.");
  chk_fast_lock_start: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (RULE24)
    apply && current_lim_reg != '0 |=> fast_lock_o [*2])
    else $error("Fast lock did not start after channel apply.");

  sequence s_commit;
    pending_reg && detector_tick_o;
  endsequence

  // Stray selects must not arm a channel write, or a later tick applies stale values.
  sequence s_stray_load;
    load_i && sel > SEL_PUMP && !pending_reg;
  endsequence

  sequence s_denref_idle;
    hit_denref && !pending_reg;
  endsequence

  chk_int_capture: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (RULE2)
    hit_channel |=> staged_reg.int_value == $past(word_i[INT_MSB:INT_LSB]))
    else $error("Integer value not staged.");

  chk_num_capture: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (RULE3)
    hit_channel |=> staged_reg.fraction_numerator == $past(word_i[NUM_MSB:NUM_LSB]))
    else $error("Fraction numerator not staged.");

  chk_boost_shadow: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (RULE4)
    hit_denref |=> shadow_reg.pump_boost == $past(word_i[BOOST_BIT]))
    else $error("Boost bit not captured in shadow.");

  chk_halve_shadow: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (RULE7)
    hit_denref |=> shadow_reg.ref_halve == $past(word_i[HALVE_BIT]))
    else $error("Halver bit not captured in shadow.");

  chk_doubler_shadow: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (RULE10)
    hit_denref |=> shadow_reg.doubler_en == $past(word_i[DOUBLE_BIT]))
    else $error("Doubler bit not captured in shadow.");

  chk_rdiv_shadow: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (RULE11)
    hit_denref |=> shadow_reg.ref_div == $past(word_i[RDIV_MSB:RDIV_LSB]))
    else $error("Reference divider not captured in shadow.");

  chk_shadow_steady: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (RULE4)
    !hit_denref && !hit_phase |=> shadow_reg == $past(shadow_reg))
    else $error("Shadow changed without a shadow write.");

  chk_denref_no_arm: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (RULE5)
    s_denref_idle |=> !pending_reg)
    else $error("Denominator write armed a channel apply.");

  chk_stray_ignored: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (RULE1)
    s_stray_load |=> !pending_reg)
    else $error("Unused select armed a channel apply.");

  chk_stray_function: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (RULE18)
    load_i && sel > SEL_PUMP |=> pump_ground_o == $past(pump_ground_o))
    else $error("Unused select changed the function bits.");

  chk_boost_apply: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (RULE6)
    apply |=> pump_boost_o == $past(shadow_reg.pump_boost))
    else $error("Boost did not follow the channel apply.");

  chk_boost_steady: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (RULE6)
    !apply |=> pump_boost_o == $past(pump_boost_o))
    else $error("Boost changed without a channel apply.");

  chk_phase_apply: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (RULE14)
    apply |=> active_o.phase_seed == $past(shadow_reg.phase_seed))
    else $error("Phase seed not applied.");

  chk_phase_waits: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (RULE15)
    hit_phase && !apply |=> active_o.phase_seed == $past(active_o.phase_seed))
    else $error("Phase seed applied without a channel write.");

  chk_channel_apply: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (RULE24)
    apply |=> channel_o == $past(staged_reg))
    else $error("Channel word not applied.");

  chk_channel_steady: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (RULE26)
    !apply |=> channel_o == $past(channel_o))
    else $error("Channel word changed without apply.");

  chk_pending_clear: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (RULE24)
    apply && !hit_channel |=> !pending_reg)
    else $error("Pending flag survived the apply.");

  chk_commit_load: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (RULE24)
    s_commit |=> modulator_load_o)
    else $error("Apply did not raise the modulator load.");

  chk_idle_no_load: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (RULE24)
    !apply |=> !modulator_load_o)
    else $error("Modulator load without an apply.");

  chk_func_steady: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (RULE18)
    !hit_function |=> detector_positive_o == $past(detector_positive_o))
    else $error("Polarity changed without a function write.");

  chk_third_select: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (RULE23)
    hit_pump && tsel == TSEL_THIRD |=> third_lim_reg == $past(count_field))
    else $error("Third switch timeout not programmed by selector.");

  chk_pair_select: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (RULE23)
    hit_pump && tsel == TSEL_PAIR |=> pair_lim_reg == $past(count_field))
    else $error("Switch pair timeout not programmed by selector.");

  chk_limits_steady: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (RULE22)
    !hit_pump |=> current_lim_reg == $past(current_lim_reg))
    else $error("Pump current timeout changed without a write.");

  chk_third_start: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (RULE24)
    apply && third_lim_reg != '0 |=> third_switch_closed_o [*2])
    else $error("Third switch did not close after apply.");

  chk_pair_start: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see (RULE24)
    apply && pair_lim_reg != '0 |=> pair_switch_closed_o [*2])
    else $error("Switch pair did not close after apply.");
endmodule
`default_nettype wire

// ### sim/sdcr_host_model.sv
`default_nettype none
module sdcr_host_model
  import sdcr_pkg::*;
(
  input  wire logic                  clk_sys_i,
  output logic                       load_o,
  output logic [sdcr_pkg::WORD_W-1:0] word_o
);
  import sdcr_pkg::*;

  initial begin
    load_o = 1'b0;
    word_o = '0;
  end

  // A released word shows its inverse, so a stale value is never taken as live.
  task automatic send(input logic [WORD_W-1:0] w);
    @(negedge clk_sys_i);
    load_o = 1'b1;
    word_o = w;
    @(negedge clk_sys_i);
    load_o = 1'b0;
    word_o = ~w;
  endtask

  function automatic logic [WORD_W-1:0] channel_w(input logic [8:0] iv, input logic [11:0] nm);
    return {iv, nm, SEL_CHANNEL};
  endfunction

  function automatic logic [WORD_W-1:0] denref_w(input logic bo, input logic ha,
      input logic pr, input logic db, input logic [3:0] rd, input logic [11:0] dn);
    return {bo, ha, 1'b0, pr, db, rd, dn, SEL_DENREF};
  endfunction

  function automatic logic [WORD_W-1:0] phase_w(input logic [11:0] ph);
    return {8'h00, 1'b0, ph, SEL_PHASE};
  endfunction

  function automatic logic [WORD_W-1:0] function_w(input logic g, input logic p);
    return {8'h00, 10'h001, g, 1'b1, p, SEL_FUNCTION};
  endfunction

  function automatic logic [WORD_W-1:0] pump_w(input logic [8:0] c, input logic [1:0] ts);
    return {10'h001, c, ts, SEL_PUMP};
  endfunction
endmodule
`default_nettype wire

// ### sim/sdcr_config_bank_bench.sv
`default_nettype none
module sdcr_config_bank_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import sdcr_pkg::*;

  logic                clk_sys_i;
  logic                reset_i;
  logic                load_i;
  logic [WORD_W-1:0]   word_i;
  logic                ref_edge_i;
  sdcr_channel_t       channel_o;
  sdcr_shadow_t        active_o;
  logic                detector_tick_o;
  logic                modulator_load_o;
  logic                fast_lock_o;
  logic                pump_boost_o;
  logic                pump_ground_o;
  logic                detector_positive_o;
  logic                pair_switch_closed_o;
  logic                third_switch_closed_o;
  int                  error_cnt = 0;
  int                  checks = 0;
  int                  rc = 0;

  sdcr_config_bank u_sdcr_config_bank (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .load_i(load_i), .word_i(word_i),
    .ref_edge_i(ref_edge_i), .channel_o(channel_o), .active_o(active_o),
    .detector_tick_o(detector_tick_o), .modulator_load_o(modulator_load_o),
    .fast_lock_o(fast_lock_o), .pump_boost_o(pump_boost_o), .pump_ground_o(pump_ground_o),
    .detector_positive_o(detector_positive_o), .pair_switch_closed_o(pair_switch_closed_o),
    .third_switch_closed_o(third_switch_closed_o)
  );

  sdcr_host_model u_sdcr_host_model (
    .clk_sys_i(clk_sys_i), .load_o(load_i), .word_o(word_i)
  );

  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  // One reference event every three system clocks keeps the count expectations exact.
  initial begin
    ref_edge_i = 1'b0;
    forever begin
      @(negedge clk_sys_i);
      rc = (rc + 1) % 3;
      ref_edge_i = (rc == 0);
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Tick phase against the reference is free, so counts may land one either side.
  task automatic near(input int got, input int exp);
    checks++;
    if (got < exp - 1 || got > exp + 1) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic int exp_ticks(input int span, input int rd, input logic db, input logic ha);
    return span / (3 * (db ? rd : 2 * rd) * (ha ? 2 : 1));
  endfunction

  task automatic apply(input logic [8:0] iv, input logic [11:0] nm);
    int n;
    u_sdcr_host_model.send(u_sdcr_host_model.channel_w(iv, nm));
    n = 0;
    while (modulator_load_o !== 1'b1 && n < 400) begin
      @(negedge clk_sys_i);
      n++;
    end
    chk(32'(modulator_load_o), 32'h1);
  endtask

  task automatic wrap_up();
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    #(30000 * 10);
    error_cnt++;
    wrap_up();
  end

  initial begin
    sdcr_shadow_t sh;
    sdcr_shadow_t prev;
    logic [8:0]   iv;
    logic [11:0]  nm;
    int           t0;
    int           t1;
    int           t2;
    time          ta;
    time          m0;
    time          m1;
    void'($urandom(11));
    reset_i = 1'b1;
    repeat (10) @(negedge clk_sys_i);
    reset_i = 1'b0;
    prev = {4'h0, RDIV_RESET, DEN_RESET, 12'h000};
    chk(active_o, prev);
    chk(32'(channel_o), 32'({INT_RESET, 12'h000}));
    chk(32'(pump_ground_o), 32'h1);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      sh = '0;
      sh.pump_boost = 1'($urandom_range(1, 0));
      sh.ref_halve = 1'($urandom_range(1, 0));
      sh.prescale_89 = 1'($urandom_range(1, 0));
      sh.doubler_en = 1'($urandom_range(1, 0));
      sh.ref_div = 4'($urandom_range(15, 1));
      sh.fraction_denominator = 12'($urandom_range(4095, 13));
      sh.phase_seed = 12'($urandom_range(sh.fraction_denominator, 0));
      iv = 9'($urandom_range(511, sh.prescale_89 ? 80 : 26));
      nm = 12'($urandom_range(sh.fraction_denominator - 1, 0));
      u_sdcr_host_model.send(u_sdcr_host_model.denref_w(sh.pump_boost, sh.ref_halve,
        sh.prescale_89, sh.doubler_en, sh.ref_div, sh.fraction_denominator));
      u_sdcr_host_model.send(u_sdcr_host_model.phase_w(sh.phase_seed));
      u_sdcr_host_model.send({21'($urandom), 3'(5 + i % 3)});
      chk(active_o, prev);
      apply(iv, nm);
      chk(active_o, sh);
      chk(32'(channel_o), 32'({iv, nm}));
      chk(32'(pump_boost_o), 32'(sh.pump_boost));
      prev = sh;
    end
    $display("test shadow done");
    for (int i = 0; i < 4; i++) begin
      u_sdcr_host_model.send(u_sdcr_host_model.denref_w(1'b0, i[1], 1'b0, i[0], 4'h3, 12'h00d));
      apply(9'h01a, 12'h000);
      t0 = 0;
      repeat (360) begin
        @(negedge clk_sys_i);
        t0 += int'(detector_tick_o === 1'b1);
      end
      near(t0, exp_ticks(360, 3, i[0], i[1]));
    end
    $display("test rate done");
    for (int i = 0; i < 4; i++) begin
      u_sdcr_host_model.send(u_sdcr_host_model.function_w(i[1], i[0]));
      @(negedge clk_sys_i);
      chk(32'(pump_ground_o), 32'(!i[1]));
      chk(32'(detector_positive_o), 32'(i[0]));
    end
    $display("test function done");
    u_sdcr_host_model.send(u_sdcr_host_model.pump_w(9'h002, TSEL_CURRENT));
    u_sdcr_host_model.send(u_sdcr_host_model.pump_w(9'h003, TSEL_THIRD));
    u_sdcr_host_model.send(u_sdcr_host_model.pump_w(9'h004, TSEL_PAIR));
    apply(9'h064, 12'h000);
    chk(32'(fast_lock_o), 32'h1);
    t0 = 0;
    t1 = 0;
    t2 = 0;
    repeat (600) begin
      @(negedge clk_sys_i);
      if (detector_tick_o === 1'b1) begin
        t0 += int'(fast_lock_o === 1'b1);
        t1 += int'(third_switch_closed_o === 1'b1);
        t2 += int'(pair_switch_closed_o === 1'b1);
      end
    end
    near(t0, 2 * TICKS_PER_UNIT);
    near(t1, 3 * TICKS_PER_UNIT);
    near(t2, 4 * TICKS_PER_UNIT);
    $display("test timers done");
    // With a divider of one, each detector cycle is one reference cycle of six clocks.
    u_sdcr_host_model.send(u_sdcr_host_model.denref_w(1'b0, 1'b0, 1'b0, 1'b0, 4'h1, 12'h00d));
    apply(9'h01a, 12'h000);
    repeat (2) begin
      @(negedge clk_sys_i);
      while (detector_tick_o !== 1'b1) @(negedge clk_sys_i);
    end
    ta = $time;
    apply(9'h01a, 12'h001);
    m0 = $time;
    while ($time < ta + 13 * 60) @(negedge clk_sys_i);
    chk(32'(detector_tick_o), 32'h1);
    @(negedge clk_sys_i);
    apply(9'h01a, 12'h002);
    m1 = $time;
    chk(32'(m1 - ta - 13 * 60), 32'(m0 - ta));
    chk(32'((m1 - m0) / 10), 32'(13 * 6));
    $display("test coherence done");
    wrap_up();
  end
endmodule
`default_nettype wire
